// ---- core/iwd_pkg.sv ----
package iwd_pkg;

    // ****************************************
    // word layout
    // ****************************************
    localparam int WORD_W = 14;
    localparam int OP_W = 6;
    localparam int ADDR_W = 7;
    localparam int BIT_W = 3;
    localparam int LIT_W = 11;
    localparam int LIT8_W = 8;
    localparam int GRP_HI = 13;
    localparam int GRP_LO = 12;
    localparam int OP_LSB = 8;
    localparam int DEST_POS = 7;
    localparam int BSEL_LSB = 7;
    localparam int BIT_TEST_POS = 11;
    localparam int JUMP_KIND_LSB = 10;
    localparam int MISC_LSB_W = 4;
    localparam logic [OP_W-1:0] OP_MISC = 6'h00;
    localparam logic [OP_W-1:0] OP_CLEAR = 6'h01;
    localparam logic [1:0] FLOW_JUMP = 2'h2;
    localparam logic [1:0] FLOW_RET_LIT = 2'h1;
    localparam logic [MISC_LSB_W-1:0] MISC_RETURN = 4'h8;
    localparam logic [MISC_LSB_W-1:0] MISC_RETINT = 4'h9;
    localparam logic [ADDR_W-1:0] ADDR_MAX = 7'h7f;

    // ****************************************
    // cycle timing
    // ****************************************
    localparam int OSC_PER_ICYC = 4;
    localparam int PH_W = 2;
    localparam logic [PH_W-1:0] PH_READ = 2'h1;
    localparam logic [PH_W-1:0] PH_WRITE = 2'h3;

    // ****************************************
    // register map
    // ****************************************
    localparam int PADDR_W = 12;
    localparam logic [PADDR_W-1:0] REG_CTRL = 12'h000;
    localparam logic [PADDR_W-1:0] REG_SOFT_WORD = 12'h004;
    localparam logic [PADDR_W-1:0] REG_DECODE = 12'h008;
    localparam logic [PADDR_W-1:0] REG_CYCLES = 12'h00c;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_SOFT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [WORD_W-1:0] WORD_RESET = 14'h0000;

    typedef enum logic [1:0] {GRP_BYTE, GRP_BIT, GRP_FLOW} iwd_group_type;
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_NOP} iwd_state_type;

    // category of a word; don't-care positions are never examined
    function automatic iwd_group_type iwd_group_of(input logic [WORD_W-1:0] w);
        if (w[GRP_HI]) begin
            return GRP_FLOW;
        end else if (w[GRP_LO]) begin
            return GRP_BIT;
        end else if (w[GRP_HI:OP_LSB] == OP_MISC && !w[DEST_POS]) begin
            return GRP_FLOW;
        end
        return GRP_BYTE;
    endfunction

endpackage

// ---- core/iwd_phase_gen.sv ----
`timescale 1ns/1ps
module iwd_phase_gen #(
    parameter int QUARTERS = iwd_pkg::OSC_PER_ICYC
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic run_in,
    output logic [iwd_pkg::PH_W-1:0] phase_out,
    output logic cyc_end_out
);
    logic [iwd_pkg::PH_W-1:0] phase_q;
    logic [iwd_pkg::PH_W-1:0] phase_d;
    localparam logic [iwd_pkg::PH_W-1:0] LAST = iwd_pkg::PH_W'(QUARTERS - 1);

    // oscillator quarter counter, parked at zero while stopped
    always_comb begin
        phase_d = phase_q;
        if (!run_in) begin
            phase_d = '0;
        end else if (phase_q == LAST) begin
            phase_d = '0;
        end else begin
            phase_d = phase_q + 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            phase_q <= '0;
        end else begin
            phase_q <= phase_d;
        end
    end

    assign phase_out = phase_q;
    assign cyc_end_out = run_in && (phase_q == LAST); // one-cycle enable
endmodule

// ---- core/iwd_field_dec.sv ----
`timescale 1ns/1ps
module iwd_field_dec #(
    parameter logic [iwd_pkg::ADDR_W-1:0] PORT_ADDR = 7'h05
) (
    input wire logic [iwd_pkg::WORD_W-1:0] word_in,
    output iwd_pkg::iwd_group_type group_out,
    output logic [iwd_pkg::OP_W-1:0] op_out,
    output logic dest_file_out,
    output logic [iwd_pkg::ADDR_W-1:0] addr_out,
    output logic [iwd_pkg::BIT_W-1:0] bit_sel_out,
    output logic [iwd_pkg::LIT_W-1:0] literal_out,
    output logic lit_wide_out,
    output logic uses_file_out,
    output logic writes_file_out,
    output logic writes_acc_out,
    output logic pc_jump_out,
    output logic clear_port_out
);
    logic [1:0] flow_kind;
    logic clear_acc;

    // fixed field slicing of the word
    // one category per word
    assign group_out = iwd_pkg::iwd_group_of(word_in);
    assign op_out = word_in[iwd_pkg::GRP_HI:iwd_pkg::OP_LSB];
    assign dest_file_out = word_in[iwd_pkg::DEST_POS];
    assign addr_out = word_in[iwd_pkg::ADDR_W-1:0];
    assign bit_sel_out = word_in[iwd_pkg::BSEL_LSB +: iwd_pkg::BIT_W];
    assign flow_kind = word_in[iwd_pkg::GRP_HI -: 2];
    assign clear_acc = (op_out == iwd_pkg::OP_CLEAR) && !dest_file_out;

    // operand use and result routing per category
    always_comb begin
        lit_wide_out = 1'b0;
        literal_out = '0;
        uses_file_out = 1'b0;
        writes_file_out = 1'b0;
        writes_acc_out = 1'b0;
        pc_jump_out = 1'b0;
        unique case (group_out)
            iwd_pkg::GRP_BYTE: begin
                // clearing the accumulator names no register
                uses_file_out = !clear_acc;
                writes_file_out = dest_file_out && !clear_acc;
                writes_acc_out = !dest_file_out;
            end
            iwd_pkg::GRP_BIT: begin
                uses_file_out = 1'b1;
                writes_file_out = !word_in[iwd_pkg::BIT_TEST_POS];
            end
            iwd_pkg::GRP_FLOW: begin
                if (flow_kind == iwd_pkg::FLOW_JUMP) begin
                    lit_wide_out = 1'b1;
                    literal_out = word_in[iwd_pkg::LIT_W-1:0];
                    pc_jump_out = 1'b1;
                end else if (word_in[iwd_pkg::GRP_HI]) begin
                    literal_out = {3'h0, word_in[iwd_pkg::LIT8_W-1:0]};
                    writes_acc_out = 1'b1;
                    pc_jump_out = word_in[iwd_pkg::JUMP_KIND_LSB +: 2] == iwd_pkg::FLOW_RET_LIT;
                end else begin
                    pc_jump_out = (word_in[iwd_pkg::MISC_LSB_W-1:0] == iwd_pkg::MISC_RETURN)
                        || (word_in[iwd_pkg::MISC_LSB_W-1:0] == iwd_pkg::MISC_RETINT);
                end
            end
        endcase
    end

    assign clear_port_out = (op_out == iwd_pkg::OP_CLEAR) && dest_file_out
        && (addr_out == PORT_ADDR);
endmodule

// ---- core/iwd_decode_core.sv ----
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
module iwd_decode_core #(
    parameter int QUARTERS = iwd_pkg::OSC_PER_ICYC,
    parameter logic [iwd_pkg::ADDR_W-1:0] PORT_ADDR = 7'h05
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [iwd_pkg::PADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [iwd_pkg::WORD_W-1:0] instr_word_in,
    output logic fetch_out,
    input wire logic cond_true_in,
    input wire logic pc_change_in,
    output logic [1:0] group_out,
    output logic [iwd_pkg::OP_W-1:0] opcode_out,
    output logic dest_file_out,
    output logic [iwd_pkg::ADDR_W-1:0] file_addr_out,
    output logic [iwd_pkg::BIT_W-1:0] bit_sel_out,
    output logic [iwd_pkg::LIT_W-1:0] literal_out,
    output logic lit_wide_out,
    output logic [iwd_pkg::PH_W-1:0] phase_out,
    output logic file_rd_out,
    output logic file_wr_out,
    output logic acc_wr_out,
    output logic nop_cycle_out,
    output logic port_read_out
);
    // ****************************************
    // apb register slave
    // ****************************************
    logic [1:0] ctrl_q;
    logic [1:0] ctrl_d;
    logic [iwd_pkg::WORD_W-1:0] soft_word_q;
    logic [iwd_pkg::WORD_W-1:0] soft_word_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic [31:0] cycles_q;
    logic [31:0] cycles_d;
    logic wr_en;
    logic rd_setup;
    logic mapped;
    logic run;
    iwd_pkg::iwd_state_type state_q;
    iwd_pkg::iwd_state_type state_d;
    logic [iwd_pkg::WORD_W-1:0] word_q;
    logic [iwd_pkg::WORD_W-1:0] word_d;

    // address decode shared by write and error paths
    assign mapped = (paddr_in == iwd_pkg::REG_CTRL) || (paddr_in == iwd_pkg::REG_SOFT_WORD)
        || (paddr_in == iwd_pkg::REG_DECODE) || (paddr_in == iwd_pkg::REG_CYCLES);
    assign wr_en = psel_in && penable_in && pwrite_in && mapped;
    assign rd_setup = psel_in && !penable_in && !pwrite_in;
    assign run = ctrl_q[iwd_pkg::CTRL_RUN];

    // writes land in the access phase, read data is captured in setup
    always_comb begin
        ctrl_d = ctrl_q;
        soft_word_d = soft_word_q;
        prdata_d = prdata_q;
        if (wr_en && paddr_in == iwd_pkg::REG_CTRL) begin
            ctrl_d = pwdata_in[1:0];
        end
        if (wr_en && paddr_in == iwd_pkg::REG_SOFT_WORD) begin
            soft_word_d = pwdata_in[iwd_pkg::WORD_W-1:0];
        end
        if (rd_setup) begin
            unique case (paddr_in)
                iwd_pkg::REG_CTRL: prdata_d = {30'h0, ctrl_q};
                iwd_pkg::REG_SOFT_WORD: prdata_d = {18'h0, soft_word_q};
                iwd_pkg::REG_DECODE: prdata_d = {14'h0, state_q, word_q, group_out};
                iwd_pkg::REG_CYCLES: prdata_d = cycles_q;
                default: prdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ctrl_q <= iwd_pkg::CTRL_RESET;
            soft_word_q <= iwd_pkg::WORD_RESET;
            prdata_q <= 32'h0;
        end else begin
            ctrl_q <= ctrl_d;
            soft_word_q <= soft_word_d;
            prdata_q <= prdata_d;
        end
    end

    assign pready_out = 1'b1; // zero wait states
    assign pslverr_out = psel_in && penable_in && !mapped;
    assign prdata_out = prdata_q;

    // ****************************************
    // cycle timing and field decode
    // ****************************************
    logic [iwd_pkg::PH_W-1:0] phase;
    logic cyc_end;
    iwd_pkg::iwd_group_type dec_group;
    logic [iwd_pkg::OP_W-1:0] dec_op;
    logic dec_dest;
    logic [iwd_pkg::ADDR_W-1:0] dec_addr;
    logic [iwd_pkg::BIT_W-1:0] dec_bit;
    logic [iwd_pkg::LIT_W-1:0] dec_lit;
    logic dec_wide;
    logic dec_uses;
    logic dec_wfile;
    logic dec_wacc;
    logic dec_jump;
    logic dec_port;

    iwd_phase_gen #(
        .QUARTERS(QUARTERS)
    ) u_phase (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .run_in(run),
        .phase_out(phase),
        .cyc_end_out(cyc_end)
    );

    // next word from program memory or the soft word register
    assign word_d = ctrl_q[iwd_pkg::CTRL_SOFT] ? soft_word_q : instr_word_in;

    iwd_field_dec #(
        .PORT_ADDR(PORT_ADDR)
    ) u_dec (
        .word_in(word_d),
        .group_out(dec_group),
        .op_out(dec_op),
        .dest_file_out(dec_dest),
        .addr_out(dec_addr),
        .bit_sel_out(dec_bit),
        .literal_out(dec_lit),
        .lit_wide_out(dec_wide),
        .uses_file_out(dec_uses),
        .writes_file_out(dec_wfile),
        .writes_acc_out(dec_wacc),
        .pc_jump_out(dec_jump),
        .clear_port_out(dec_port)
    );

    // ****************************************
    // instruction sequencer
    // ****************************************
    logic flush_q;
    logic flush_d;
    logic take;
    logic exec;
    logic uses_q;
    logic wfile_q;
    logic wacc_q;
    logic jump_q;
    logic port_q;
    logic [1:0] group_q;
    logic [iwd_pkg::OP_W-1:0] op_q;
    logic dest_q;
    logic [iwd_pkg::ADDR_W-1:0] addr_q;
    logic [iwd_pkg::BIT_W-1:0] bit_q;
    logic [iwd_pkg::LIT_W-1:0] lit_q;
    logic wide_q;

    // a taken test or jump forces one idle cycle
    always_comb begin
        state_d = state_q;
        flush_d = flush_q;
        take = 1'b0;
        if (state_q == iwd_pkg::ST_EXEC && phase == iwd_pkg::PH_WRITE) begin
            flush_d = flush_q || jump_q || cond_true_in || pc_change_in;
        end
        if (!run) begin
            state_d = iwd_pkg::ST_IDLE;
            flush_d = 1'b0;
        end else if (cyc_end || state_q == iwd_pkg::ST_IDLE) begin
            unique case (state_q)
                iwd_pkg::ST_IDLE, iwd_pkg::ST_NOP: begin
                    state_d = iwd_pkg::ST_EXEC;
                    take = cyc_end;
                end
                iwd_pkg::ST_EXEC: begin
                    state_d = flush_d ? iwd_pkg::ST_NOP : iwd_pkg::ST_EXEC;
                    take = !flush_d;
                end
            endcase
            flush_d = 1'b0;
        end
        if (state_q == iwd_pkg::ST_IDLE) begin
            state_d = run ? iwd_pkg::ST_NOP : iwd_pkg::ST_IDLE;
            take = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_q <= iwd_pkg::ST_IDLE;
            flush_q <= 1'b0;
        end else begin
            state_q <= state_d;
            flush_q <= flush_d;
        end
    end

    // captured word and its decoded fields, held for the whole cycle
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            word_q <= iwd_pkg::WORD_RESET;
            group_q <= 2'h0;
            op_q <= '0;
            dest_q <= 1'b0;
            addr_q <= '0;
            bit_q <= '0;
            lit_q <= '0;
            wide_q <= 1'b0;
            uses_q <= 1'b0;
            wfile_q <= 1'b0;
            wacc_q <= 1'b0;
            jump_q <= 1'b0;
            port_q <= 1'b0;
        end else if (take) begin
            word_q <= word_d;
            group_q <= dec_group;
            op_q <= dec_op;
            dest_q <= dec_dest;
            addr_q <= dec_addr;
            bit_q <= dec_bit;
            lit_q <= dec_lit;
            wide_q <= dec_wide;
            uses_q <= dec_uses;
            wfile_q <= dec_wfile;
            wacc_q <= dec_wacc;
            jump_q <= dec_jump;
            port_q <= dec_port;
        end
    end

    // instruction cycle counter for software
    always_comb begin
        cycles_d = cyc_end ? cycles_q + 32'h1 : cycles_q;
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cycles_q <= 32'h0;
        end else begin
            cycles_q <= cycles_d;
        end
    end

    // ****************************************
    // datapath strobes
    // ****************************************
    assign exec = state_q == iwd_pkg::ST_EXEC;
    assign fetch_out = take;
    assign group_out = group_q;
    assign opcode_out = op_q;
    assign dest_file_out = dest_q;
    assign file_addr_out = addr_q;
    assign bit_sel_out = bit_q;
    assign literal_out = lit_q;
    assign lit_wide_out = wide_q;
    assign phase_out = phase;
    assign nop_cycle_out = state_q == iwd_pkg::ST_NOP;
    assign file_rd_out = exec && uses_q && phase == iwd_pkg::PH_READ;
    assign file_wr_out = exec && wfile_q && phase == iwd_pkg::PH_WRITE;
    assign acc_wr_out = exec && wacc_q && phase == iwd_pkg::PH_WRITE;
    assign port_read_out = file_rd_out && port_q;

    // ****************************************
    // assertions
    // ****************************************
    a_group_match: assert property (@(posedge clk_in) disable iff (srst_in)
        $rose(fetch_out) or fetch_out |=> group_q == iwd_pkg::iwd_group_of(word_q))
        else $error("group does not match captured word");
    a_byte_fields: assert property (@(posedge clk_in) disable iff (srst_in)
        take |=> {opcode_out, dest_file_out, file_addr_out} == $past(word_d))
        else $error("byte format fields misplaced");
    a_addr_direct: assert property (@(posedge clk_in) disable iff (srst_in)
        file_rd_out |-> file_addr_out == word_q[6:0] && file_addr_out <= iwd_pkg::ADDR_MAX)
        else $error("register address not the low seven bits");
    a_dest_route: assert property (@(posedge clk_in) disable iff (srst_in)
        exec && phase == iwd_pkg::PH_WRITE && group_q == iwd_pkg::GRP_BYTE && uses_q
        |-> file_wr_out == word_q[7] && acc_wr_out == !word_q[7])
        else $error("destination select misrouted");
    a_bit_pick: assert property (@(posedge clk_in) disable iff (srst_in)
        exec && group_q == iwd_pkg::GRP_BIT |-> bit_sel_out == word_q[9:7] && uses_q)
        else $error("bit select wrong");
    a_literal_width: assert property (@(posedge clk_in) disable iff (srst_in)
        exec && group_q == iwd_pkg::GRP_FLOW && word_q[13]
        |-> (wide_q ? literal_out == word_q[10:0] : literal_out == {3'h0, word_q[7:0]}))
        else $error("literal width wrong");
    a_quad_cycle: assert property (@(posedge clk_in) disable iff (srst_in || !run)
        cyc_end |=> !cyc_end [*3] ##1 cyc_end)
        else $error("instruction cycle not four periods");
    a_nop_second: assert property (@(posedge clk_in) disable iff (srst_in || !run)
        exec && cyc_end && (jump_q || cond_true_in || pc_change_in) |=> nop_cycle_out [*4] ##1 exec)
        else $error("taken branch did not idle one cycle");
    a_read_first: assert property (@(posedge clk_in) disable iff (srst_in)
        file_wr_out |-> $past(file_rd_out, 2))
        else $error("register written without prior read");
    a_port_reread: assert property (@(posedge clk_in) disable iff (srst_in)
        port_read_out |-> file_rd_out ##2 file_wr_out)
        else $error("port clear not read then written");
    c_byte_write: cover property (@(posedge clk_in) file_wr_out && group_q == iwd_pkg::GRP_BYTE);
    c_bit_op: cover property (@(posedge clk_in) file_rd_out && group_q == iwd_pkg::GRP_BIT);
    c_jump_nop: cover property (@(posedge clk_in) exec && jump_q ##4 nop_cycle_out);
    c_port_clear: cover property (@(posedge clk_in) port_read_out);
endmodule

// ---- tb/iwd_prog_model.sv ----
`timescale 1ns/1ps
module iwd_prog_model (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic fetch_in,
    input wire logic nop_in,
    input wire logic [1:0] phase_in,
    output logic [13:0] word_out,
    output logic cond_out,
    output logic pc_out
);
    // ****************************************
    // program store
    // ****************************************
    // bits 13:0 word, bit 14 taken test, bit 15 pc change by datapath
    localparam int N = 12;
    // don't-cares zero; word 2 sets them to show they change nothing
    localparam logic [15:0] PROG [0:N-1] = '{16'h0785, 16'h0185, 16'h0155, 16'h0aff,
        16'h4b20, 16'h1780, 16'h1c7f, 16'h3055, 16'h2923, 16'h0008, 16'h8080, 16'h0000};
    int idx_q;
    int ex;

    // advance one word per fetch strobe
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            idx_q <= 0;
        end else if (fetch_in) begin
            idx_q <= (idx_q + 1) % N;
        end
    end

    // word only valid while fetched, inverted otherwise
    always_comb begin
        ex = (idx_q + N - 1) % N;
        word_out = fetch_in ? PROG[idx_q][13:0] : ~PROG[idx_q][13:0];
        cond_out = (phase_in == 2'h3) && !nop_in && PROG[ex][14];
        pc_out = (phase_in == 2'h3) && !nop_in && PROG[ex][15];
    end
endmodule

// ---- tb/instr_word_decode_timing_tb.sv ----
`timescale 1ns/1ps
module instr_word_decode_timing_tb;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, fetch, cond_true, pc_change, dest, lit_wide;
    logic file_rd, file_wr, acc_wr, nop_cyc, port_read;
    logic [13:0] word;
    logic [1:0] group, phase;
    logic [5:0] opcode;
    logic [6:0] faddr;
    logic [2:0] bsel;
    logic [10:0] literal;
    int mismatches = 0;
    int total_checks = 0;

    iwd_decode_core dut_u (.clk_in(clk_in), .srst_in(srst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .instr_word_in(word), .fetch_out(fetch), .cond_true_in(cond_true),
        .pc_change_in(pc_change), .group_out(group), .opcode_out(opcode),
        .dest_file_out(dest), .file_addr_out(faddr), .bit_sel_out(bsel),
        .literal_out(literal), .lit_wide_out(lit_wide), .phase_out(phase),
        .file_rd_out(file_rd), .file_wr_out(file_wr), .acc_wr_out(acc_wr),
        .nop_cycle_out(nop_cyc), .port_read_out(port_read));

    iwd_prog_model pm_u (.clk_in(clk_in), .srst_in(srst_in), .fetch_in(fetch),
        .nop_in(nop_cyc), .phase_in(phase), .word_out(word), .cond_out(cond_true),
        .pc_out(pc_change));

    // 100 MHz clock
    initial begin
        forever #5 clk_in = ~clk_in;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
        total_checks++;
        if (got !== ex) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", nm, ex, got);
        end
    endtask

    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_in);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one fetched word through its cycle and any idle cycle
    task automatic run_instr(input logic [15:0] e);
        logic [13:0] w;
        logic [1:0] g;
        logic lw, jmp, rd, wr, prt, acc;
        logic [10:0] lit;
        w = e[13:0];
        g = w[13] ? 2'h2 : w[12] ? 2'h1 : (w[13:8] == 6'h00 && !w[7]) ? 2'h2 : 2'h0;
        lw = (w[13:12] == 2'h2);
        lit = lw ? w[10:0] : (w[13:12] == 2'h3) ? {3'h0, w[7:0]} : 11'h000;
        jmp = lw || w[13:10] == 4'hd || w == 14'h0008 || w == 14'h0009 || e[14] || e[15];
        rd = (g == 2'h1) || (g == 2'h0 && !(w[13:8] == 6'h01 && !w[7]));
        wr = (g == 2'h0 && w[7]) || (g == 2'h1 && !w[11]);
        prt = (w[13:7] == 7'h03) && (w[6:0] == 7'h05);
        acc = ((g == 2'h0) && !w[7]) || (w[13:12] == 2'h3);
        for (int p = 0; p < 4; p++) begin
            @(negedge clk_in);
            check("phase", 32'(p), phase);
            check("group", g, group);
            check("opcode", w[13:8], opcode);
            check("dest", w[7], dest);
            check("addr", w[6:0], faddr);
            check("bitsel", w[9:7], bsel);
            check("literal", {lw, lit}, {lit_wide, literal});
            check("rd", p == 1 && rd, file_rd);
            check("port", p == 1 && prt, port_read);
            check("wr", p == 3 && wr, file_wr);
            check("acc", p == 3 && acc, acc_wr);
            check("fetch", p == 3 && !jmp, fetch);
            check("nop", 1'b0, nop_cyc);
        end
        for (int p = 0; p < 4 && jmp; p++) begin
            @(negedge clk_in);
            check("nop", 1'b1, nop_cyc);
            check("idle", 2'h0, {file_rd, file_wr});
            check("fetch", p == 3, fetch);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        logic [31:0] q;
        logic e;
        repeat (12) @(posedge clk_in);
        srst_in <= 1'b0;
        apb(1'b0, iwd_pkg::REG_CTRL, 32'h0, q, e);
        check("ctrl", 32'h0, q);
        apb(1'b0, iwd_pkg::REG_CYCLES, 32'h0, q, e);
        check("cycles", 32'h0, q);
        apb(1'b1, iwd_pkg::REG_DECODE, 32'hffffffff, q, e);
        apb(1'b0, iwd_pkg::REG_DECODE, 32'h0, q, e);
        check("decode", 32'h0, q);
        apb(1'b1, iwd_pkg::REG_SOFT_WORD, 32'h00002abc, q, e);
        apb(1'b0, iwd_pkg::REG_SOFT_WORD, 32'h0, q, e);
        check("soft", 32'h00002abc, q);
        apb(1'b0, 12'h010, 32'h0, q, e);
        check("slverr", 1'b1, e);
        check("unmapped", 32'h0, q);
        // run from program memory
        apb(1'b1, iwd_pkg::REG_CTRL, 32'h00000001, q, e);
        do begin
            @(negedge clk_in);
        end while (fetch !== 1'b1);
        for (int i = 0; i < pm_u.N; i++) begin
            run_instr(pm_u.PROG[i]);
        end
        apb(1'b1, iwd_pkg::REG_CTRL, 32'h0, q, e);
        // one start-up cycle, twelve words and four idle cycles
        apb(1'b0, iwd_pkg::REG_CYCLES, 32'h0, q, e);
        check("cycles", 32'h00000011, q);
        apb(1'b0, iwd_pkg::REG_DECODE, 32'h0, q, e);
        check("decode", 32'h00001e14, q);
        // return with literal taken from the soft word register
        apb(1'b1, iwd_pkg::REG_SOFT_WORD, 32'h00003455, q, e);
        apb(1'b1, iwd_pkg::REG_CTRL, 32'h00000003, q, e);
        do begin
            @(negedge clk_in);
        end while (fetch !== 1'b1);
        run_instr(16'h3455);
        apb(1'b1, iwd_pkg::REG_CTRL, 32'h0, q, e);
        finish_test();
    end

    // watchdog against a hung handshake
    initial begin
        repeat (4000) @(posedge clk_in);
        mismatches++;
        finish_test();
    end
endmodule
